// ---- gdr_regs.sv ----
// Serial register bank of the half-bridge gate driver
module gdr_regs (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic             spi_sclk,
    input  wire logic             spi_ncs,
    input  wire logic             spi_sdi,
    output logic                  spi_sdo,
    output logic                  spi_sdo_oe,
    input  wire logic             bridge_input_a_pin,
    input  wire logic             bridge_input_b_pin,
    input  wire logic             settings_reset,
    input  wire gdr_pkg::gdr_fault_s fault_events,
    output logic                  bridge_input_a,
    output logic                  bridge_input_b,
    output gdr_pkg::gdr_fault_s   fault_latched,
    output gdr_pkg::gdr_cfg_s     cfg
);
    import gdr_pkg::*;

    typedef struct packed {
        logic [1:0]  sclk_sy;
        logic [1:0]  ncs_sy;
        logic [1:0]  sdi_sy;
        logic [1:0]  in_a_sy;
        logic [1:0]  in_b_sy;
        logic [1:0]  rst_sy;
        logic [8:0]  flt_sy0;
        logic [8:0]  flt_sy1;
        logic        sclk_prev;
        logic        ncs_prev;
        logic [4:0]  bit_cnt;
        logic [15:0] rx;
        logic [7:0]  tx;
        logic        sdo;
        gdr_fault_s  flt;
        logic [1:0]  main_rsv;
        logic        locked;
        logic        in_a;
        logic        in_b;
        logic [7:0]  drive_wd;
        logic [7:0]  oc_mon;
        logic [7:0]  chop;
        logic        eff_a;
        logic        eff_b;
    } gdr_state_s;

    localparam gdr_state_s STATE_RESET = '{
        sclk_sy:   2'h0,
        ncs_sy:    2'h3,
        sdi_sy:    2'h0,
        in_a_sy:   2'h0,
        in_b_sy:   2'h0,
        rst_sy:    2'h0,
        flt_sy0:   9'h000,
        flt_sy1:   9'h000,
        sclk_prev: 1'b0,
        ncs_prev:  1'b1,
        bit_cnt:   5'h00,
        rx:        16'h0000,
        tx:        8'h00,
        sdo:       1'b0,
        flt:       FAULT_RESET,
        main_rsv:  MAIN_RSV_RESET,
        locked:    1'b0,
        in_a:      1'b0,
        in_b:      1'b0,
        drive_wd:  DRIVE_WD_RESET,
        oc_mon:    OC_MON_RESET,
        chop:      CHOP_RESET,
        eff_a:     1'b0,
        eff_b:     1'b0
    };

    gdr_state_s s_q;
    gdr_state_s s_d;

    // Summary byte is rebuilt from the latched flags on every read
    function automatic logic [7:0] summary_byte(input gdr_fault_s f);
        logic [6:0] low;
        low = {f.watchdog_timeout_flag,
               f.high_side_gate_fault | f.low_side_gate_fault,
               f.high_side_overcurrent | f.low_side_overcurrent,
               f.supply_undervoltage_flag,
               f.pump_undervoltage_flag,
               f.thermal_shutdown_flag,
               f.thermal_warning_flag};
        summary_byte = {|low[6:1], low};
    endfunction : summary_byte

    function automatic logic [7:0] read_reg(input logic [3:0] addr, input gdr_state_s s);
        logic [7:0] v;
        v = 8'h00;
        if (addr == ADDR_FAULT_SUMMARY) begin
            v = summary_byte(s.flt);
        end else if (addr == ADDR_FET_DETAIL) begin
            v = {2'b00, s.flt.high_side_gate_fault, s.flt.low_side_gate_fault,
                 2'b00, s.flt.high_side_overcurrent, s.flt.low_side_overcurrent};
        end else if (addr == ADDR_MAIN) begin
            // Clear bit always reads zero
            v = {s.main_rsv, (s.locked ? LOCK_KEY : UNLOCK_KEY),
                 s.in_a, s.in_b, 1'b0};
        end else if (addr == ADDR_DRIVE_WD) begin
            v = s.drive_wd;
        end else if (addr == ADDR_OC_MONITOR) begin
            v = s.oc_mon & OC_MON_WMASK;
        end else if (addr == ADDR_CHOP_CFG) begin
            v = s.chop;
        end else begin
            v = 8'h00;
        end
        read_reg = v;
    endfunction : read_reg

    logic        sclk_fall;
    logic        sclk_rise;
    logic        frame_on;
    logic        frame_start;
    logic        frame_end;
    logic [15:0] rx_next;
    logic        wr_done;
    logic [3:0]  wr_addr;
    logic [7:0]  wr_data;
    logic [2:0]  wr_key;
    logic        clr_pulse;
    gdr_fault_s  flt_set;

    always_comb begin
        s_d = s_q;

        // Pin synchronisers; only second stages are read below
        s_d.sclk_sy = {s_q.sclk_sy[0], spi_sclk};
        s_d.ncs_sy  = {s_q.ncs_sy[0], spi_ncs};
        s_d.sdi_sy  = {s_q.sdi_sy[0], spi_sdi};
        s_d.in_a_sy = {s_q.in_a_sy[0], bridge_input_a_pin};
        s_d.in_b_sy = {s_q.in_b_sy[0], bridge_input_b_pin};
        s_d.rst_sy  = {s_q.rst_sy[0], settings_reset};
        s_d.flt_sy0 = fault_events;
        s_d.flt_sy1 = s_q.flt_sy0;
        s_d.sclk_prev = s_q.sclk_sy[1];
        s_d.ncs_prev  = s_q.ncs_sy[1];

        frame_on    = ~s_q.ncs_sy[1];
        frame_start = s_q.ncs_prev & ~s_q.ncs_sy[1];
        frame_end   = ~s_q.ncs_prev & s_q.ncs_sy[1];
        sclk_fall   = frame_on & s_q.sclk_prev & ~s_q.sclk_sy[1];
        sclk_rise   = frame_on & ~s_q.sclk_prev & s_q.sclk_sy[1];
        rx_next     = {s_q.rx[14:0], s_q.sdi_sy[1]};

        if (frame_start) begin
            s_d.bit_cnt = 5'h00;
            s_d.sdo     = 1'b0;
        end else if (sclk_fall) begin
            // Input captured on the falling edge, most significant bit first
            s_d.rx = rx_next;
            if (s_q.bit_cnt != FRAME_OVER) begin
                s_d.bit_cnt = s_q.bit_cnt + 5'h01;
            end
            if (s_q.bit_cnt == FRAME_HDR_END - 5'h01) begin
                // Snapshot before any write lands, so a write echoes old contents
                s_d.tx = read_reg(rx_next[6:3], s_q);
            end
        end else if (sclk_rise) begin
            if (s_q.bit_cnt >= FRAME_HDR_END && s_q.bit_cnt < FRAME_BITS) begin
                s_d.sdo = s_q.tx[3'(FRAME_BITS - 5'h01 - s_q.bit_cnt)];
            end else begin
                s_d.sdo = 1'b0;
            end
        end

        // Short or long frames are dropped without effect
        wr_done   = frame_end & (s_q.bit_cnt == FRAME_BITS) & ~s_q.rx[FRAME_RW_BIT];
        wr_addr   = s_q.rx[FRAME_ADDR_LSB +: 4];
        wr_data   = s_q.rx[7:0];
        wr_key    = wr_data[MAIN_LOCK_LSB +: 3];
        clr_pulse = 1'b0;

        if (wr_done) begin
            if (wr_addr == ADDR_MAIN) begin
                s_d.main_rsv = wr_data[MAIN_RSV_LSB +: 2];
                s_d.in_a     = wr_data[MAIN_IN_A_BIT];
                s_d.in_b     = wr_data[MAIN_IN_B_BIT];
                clr_pulse    = wr_data[MAIN_CLR_BIT];
                if (!s_q.locked && wr_key == LOCK_KEY) begin
                    s_d.locked = 1'b1;
                end else if (!s_q.locked) begin
                    s_d.locked = 1'b0;
                end else if (wr_key == UNLOCK_KEY) begin
                    s_d.locked = 1'b0;
                end else begin
                    s_d.locked = 1'b1;
                end
            end else if (wr_addr == ADDR_DRIVE_WD && !s_q.locked) begin
                s_d.drive_wd = wr_data;
            end else if (wr_addr == ADDR_OC_MONITOR && !s_q.locked) begin
                s_d.oc_mon = wr_data & OC_MON_WMASK;
            end else if (wr_addr == ADDR_CHOP_CFG && !s_q.locked) begin
                s_d.chop = wr_data;
            end
            // Status addresses and unlisted addresses take no write
        end

        // A fault arriving with the clear stays latched
        flt_set = gdr_fault_s'(s_q.flt_sy1);
        if (clr_pulse) begin
            s_d.flt = flt_set;
        end else begin
            s_d.flt = s_q.flt | flt_set;
        end

        // Settings held at defaults while the supply or sleep monitor asks
        if (s_q.rst_sy[1]) begin
            s_d.main_rsv = MAIN_RSV_RESET;
            s_d.locked   = 1'b0;
            s_d.in_a     = 1'b0;
            s_d.in_b     = 1'b0;
            s_d.drive_wd = DRIVE_WD_RESET;
            s_d.oc_mon   = OC_MON_RESET;
            s_d.chop     = CHOP_RESET;
        end

        s_d.eff_a = s_d.in_a | s_q.in_a_sy[1];
        s_d.eff_b = s_d.in_b | s_q.in_b_sy[1];
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign spi_sdo        = s_q.sdo;
    assign spi_sdo_oe     = ~s_q.ncs_sy[1];
    assign bridge_input_a = s_q.eff_a;
    assign bridge_input_b = s_q.eff_b;
    assign fault_latched  = s_q.flt;
    assign cfg.drive_strength_watchdog_control = s_q.drive_wd;
    assign cfg.overcurrent_monitor_control     = s_q.oc_mon;
    assign cfg.chopping_config_control         = s_q.chop;
    assign cfg.registers_locked                = s_q.locked;

endmodule : gdr_regs

// ---- gdr_pkg.sv ----
// Package with register map, field layout, reset values and carriers for the gate driver registers
package gdr_pkg;

    localparam logic [3:0] ADDR_FAULT_SUMMARY = 4'h0;
    localparam logic [3:0] ADDR_FET_DETAIL    = 4'h1;
    localparam logic [3:0] ADDR_MAIN          = 4'h2;
    localparam logic [3:0] ADDR_DRIVE_WD      = 4'h3;
    localparam logic [3:0] ADDR_OC_MONITOR    = 4'h4;
    localparam logic [3:0] ADDR_CHOP_CFG      = 4'h5;

    localparam int FRAME_RW_BIT   = 15;
    localparam int FRAME_ADDR_LSB = 11;
    localparam logic [4:0] FRAME_BITS    = 5'h10;
    localparam logic [4:0] FRAME_OVER    = 5'h11;
    localparam logic [4:0] FRAME_HDR_END = 5'h08;

    localparam int MAIN_RSV_LSB  = 6;
    localparam int MAIN_LOCK_LSB = 3;
    localparam int MAIN_IN_A_BIT = 2;
    localparam int MAIN_IN_B_BIT = 1;
    localparam int MAIN_CLR_BIT  = 0;

    localparam logic [2:0] LOCK_KEY   = 3'h6;
    localparam logic [2:0] UNLOCK_KEY = 3'h3;

    localparam logic [7:0] MAIN_RESET     = 8'h18;
    localparam logic [7:0] DRIVE_WD_RESET = 8'h07;
    localparam logic [7:0] OC_MON_RESET   = 8'h70;
    localparam logic [7:0] CHOP_RESET     = 8'h01;
    localparam logic [7:0] OC_MON_WMASK   = 8'hF3;
    localparam logic [1:0] MAIN_RSV_RESET = 2'h0;

    // Fault event inputs from the analog monitors
    typedef struct packed {
        logic watchdog_timeout_flag;
        logic high_side_gate_fault;
        logic low_side_gate_fault;
        logic high_side_overcurrent;
        logic low_side_overcurrent;
        logic supply_undervoltage_flag;
        logic pump_undervoltage_flag;
        logic thermal_shutdown_flag;
        logic thermal_warning_flag;
    } gdr_fault_s;

    localparam gdr_fault_s FAULT_RESET = '0;

    // Settings handed to the analog and timing logic
    typedef struct packed {
        logic [7:0] drive_strength_watchdog_control;
        logic [7:0] overcurrent_monitor_control;
        logic [7:0] chopping_config_control;
        logic       registers_locked;
    } gdr_cfg_s;

endpackage : gdr_pkg

// ---- gdr_regs_assertions.sv ----
// Checker for the gate driver register bank
module gdr_regs_chk (
    input wire logic                core_clk,
    input wire logic                rstn,
    input wire logic                spi_sclk,
    input wire logic                spi_ncs,
    input wire logic                spi_sdi,
    input wire logic                spi_sdo,
    input wire logic                spi_sdo_oe,
    input wire logic                bridge_input_a_pin,
    input wire logic                bridge_input_b_pin,
    input wire logic                settings_reset,
    input wire gdr_pkg::gdr_fault_s fault_events,
    input wire logic                bridge_input_a,
    input wire logic                bridge_input_b,
    input wire gdr_pkg::gdr_fault_s fault_latched,
    input wire gdr_pkg::gdr_cfg_s   cfg
);
    import gdr_pkg::*;
    logic [2:0] up_q;
    logic [8:0] ev;
    logic [8:0] fl;
    assign ev = fault_events;
    assign fl = fault_latched;
    // Sync pipelines still hold reset values just after release
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) up_q <= 3'h0;
        else if (up_q != 3'h7) up_q <= up_q + 3'h1;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn || up_q != 3'h7);
    sequence ncs_idle; spi_ncs [*4]; endsequence
    sequence ncs_busy; !spi_ncs [*4]; endsequence
    sequence pin_a_held; bridge_input_a_pin [*4]; endsequence
    sequence pin_b_held; bridge_input_b_pin [*4]; endsequence
    sequence srst_held; settings_reset [*4]; endsequence
    sequence quiet; (!spi_ncs && !settings_reset) [*5]; endsequence
    chk_oe_off: assert property (ncs_idle |-> !spi_sdo_oe)
        else $error("sdo driven while deselected");
    chk_oe_on: assert property (ncs_busy |-> spi_sdo_oe)
        else $error("sdo not driven in frame");
    chk_in_a_pin: assert property (pin_a_held |=> bridge_input_a)
        else $error("input a ignores its pin");
    chk_in_b_pin: assert property (pin_b_held |=> bridge_input_b)
        else $error("input b ignores its pin");
    chk_fault_set: assert property (($past(ev, 3) & $past(ev, 4) & ~fl) == 9'h0)
        else $error("fault event not latched");
    chk_fault_keep: assert property (|($past(fl) & ~fl) |-> spi_ncs)
        else $error("fault dropped without clear");
    chk_rsv_zero: assert property (cfg.overcurrent_monitor_control[3:2] == 2'h0)
        else $error("reserved monitor bits set");
    chk_srst_dflt: assert property (srst_held |=>
        cfg == {DRIVE_WD_RESET, OC_MON_RESET, CHOP_RESET, 1'b0})
        else $error("settings not at defaults");
    chk_cfg_quiet: assert property (quiet |-> $stable(cfg))
        else $error("settings moved mid frame");
endmodule : gdr_regs_chk

bind gdr_regs gdr_regs_chk chk_u (.core_clk(core_clk), .rstn(rstn), .spi_sclk(spi_sclk),
    .spi_ncs(spi_ncs), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .bridge_input_a_pin(bridge_input_a_pin), .bridge_input_b_pin(bridge_input_b_pin),
    .settings_reset(settings_reset), .fault_events(fault_events),
    .bridge_input_a(bridge_input_a), .bridge_input_b(bridge_input_b),
    .fault_latched(fault_latched), .cfg(cfg));

// ---- gdr_spi_host.sv ----
// Serial host model that frames commands for the register bank
module gdr_spi_host (
    input  wire logic core_clk,
    output logic      spi_sclk,
    output logic      spi_ncs,
    output logic      spi_sdi,
    input  wire logic spi_sdo
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        spi_sclk = 1'b0;
        spi_ncs = 1'b1;
        spi_sdi = 1'b0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step
    // Clock rests low; a released sdi shows the inverse of its last bit
    task automatic xfer(input logic [15:0] cmd, input int n, output logic [7:0] rsp);
        spi_ncs = 1'b0;
        for (int i = 0; i < n; i++) begin
            step(5);
            spi_sclk = 1'b1;
            spi_sdi = cmd[15-i];
            step(5);
            spi_sclk = 1'b0;
            rsp = {rsp[6:0], spi_sdo};
        end
        step(5);
        spi_ncs = 1'b1;
        spi_sdi = ~spi_sdi;
        step(60);
    endtask : xfer
endmodule : gdr_spi_host

// ---- tb_top.sv ----
// Self-checking bench for the gate driver register bank
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import gdr_pkg::*;
    logic       core_clk, rstn, sclk, ncs, sdi, sdo, pin_a, pin_b, srst, in_a, in_b;
    logic       sdo_oe, sdo_bus;
    logic [8:0] flt;
    gdr_fault_s ev;
    gdr_cfg_s   cfg;
    logic [7:0] rd, exp3;
    int         errors, n_tests;
    logic [7:0] dflt [7] = '{8'h00, 8'h00, MAIN_RESET, 8'h07, 8'h70, 8'h01, 8'h00};
    logic [7:0] lk_wr [5] = '{8'h28, 8'h30, 8'h08, 8'h18, 8'hF0};
    logic [7:0] lk_rd [5] = '{8'h18, 8'h30, 8'h30, 8'h18, 8'hF0};
    logic       lk_on [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    gdr_regs dut_u (.core_clk(core_clk), .rstn(rstn), .spi_sclk(sclk), .spi_ncs(ncs),
        .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .bridge_input_a_pin(pin_a),
        .bridge_input_b_pin(pin_b), .settings_reset(srst), .fault_events(ev),
        .bridge_input_a(in_a), .bridge_input_b(in_b), .fault_latched(flt), .cfg(cfg));
    // Released sdo has no pull; show the inverse so a stale bit is never taken
    assign sdo_bus = sdo_oe ? sdo : ~sdo;
    gdr_spi_host host_u (.core_clk(core_clk), .spi_sclk(sclk), .spi_ncs(ncs),
        .spi_sdi(sdi), .spi_sdo(sdo_bus));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        host_u.xfer({1'b0, a, 3'h0, d}, 16, rd);
    endtask : wr
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host_u.xfer({1'b1, a, 3'h0, 8'h00}, 16, v);
        chk(v, exp);
    endtask : rd_chk
    function automatic logic [7:0] sum_of(input logic [8:0] f);
        return {|f[8:1], f[8], f[7] | f[6], f[5] | f[4], f[3:0]};
    endfunction : sum_of
    task automatic wait_clk(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_clk
    task automatic stop_test;
        if (errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    // A hung handshake would otherwise stall the run forever
    initial begin
        #400us;
        errors++;
        stop_test();
    end

    initial begin
        {rstn, pin_a, pin_b, srst, errors, n_tests} = '0;
        ev = FAULT_RESET;
        wait_clk(4);
        rstn = 1'b1;
        wait_clk(6);
        for (int i = 0; i < 7; i++) begin
            rd_chk(4'(i), dflt[i]);
        end
        wr(ADDR_DRIVE_WD, 8'hA5);
        chk(rd, 8'h07);
        chk({7'h0, sdo_oe}, 8'h00);
        chk(cfg.drive_strength_watchdog_control, 8'hA5);
        wr(ADDR_OC_MONITOR, 8'hFF);
        rd_chk(ADDR_OC_MONITOR, 8'hF3);
        wr(ADDR_FAULT_SUMMARY, 8'hFF);
        rd_chk(ADDR_FAULT_SUMMARY, 8'h00);
        wr(ADDR_FET_DETAIL, 8'hFF);
        rd_chk(ADDR_FET_DETAIL, 8'h00);
        host_u.xfer({1'b0, ADDR_CHOP_CFG, 3'h0, 8'hAA}, 15, rd);
        rd_chk(ADDR_CHOP_CFG, 8'h01);
        wr(ADDR_CHOP_CFG, 8'hC3);
        rd_chk(ADDR_CHOP_CFG, 8'hC3);
        exp3 = 8'hA5;
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_MAIN, lk_wr[i]);
            rd_chk(ADDR_MAIN, lk_rd[i]);
            wr(ADDR_DRIVE_WD, 8'(8'h40 + i));
            if (!lk_on[i]) exp3 = 8'(8'h40 + i);
            chk(cfg.drive_strength_watchdog_control, exp3);
        end
        srst = 1'b1;
        wait_clk(8);
        chk({cfg.drive_strength_watchdog_control}, 8'h07);
        chk({7'h0, cfg.registers_locked}, 8'h00);
        chk(cfg.chopping_config_control, CHOP_RESET);
        srst = 1'b0;
        wait_clk(4);
        rd_chk(ADDR_MAIN, MAIN_RESET);
        for (int j = 0; j < 16; j++) begin
            {pin_a, pin_b} = {j[1], j[0]};
            wr(ADDR_MAIN, {5'h03, j[3], j[2], 1'b0});
            chk({6'h0, in_a, in_b}, {6'h0, j[3] | j[1], j[2] | j[0]});
        end
        for (int k = 0; k < 9; k++) begin
            ev = gdr_fault_s'(9'h1 << k);
            wait_clk(8);
            ev = FAULT_RESET;
            chk(8'(flt >> 1), 8'((9'h1 << k) >> 1));
            chk({7'h0, flt[0]}, {7'h0, k == 0});
            rd_chk(ADDR_FAULT_SUMMARY, sum_of(9'h1 << k));
            rd_chk(ADDR_FET_DETAIL, {2'h0, k == 7, k == 6, 2'h0, k == 5, k == 4});
            wr(ADDR_MAIN, 8'h19);
            rd_chk(ADDR_MAIN, 8'h18);
            rd_chk(ADDR_FAULT_SUMMARY, 8'h00);
            chk(8'(flt >> 1), 8'h00);
        end
        // A fault still asserted while the clear lands stays latched
        ev = gdr_fault_s'(9'h001);
        wait_clk(8);
        wr(ADDR_MAIN, 8'h19);
        chk({7'h0, flt[0]}, 8'h01);
        stop_test();
    end
endmodule : tb_top
